// *** logic/lbfh_pkg.sv ***
// Behaviour
// - Sample rate is master clock over (N+1)*16
// - Wait mode unaffected; enabled interrupts wake processor
// - Halt freezes registers and suspends all frames
// - Frame-done and watchdog sources, separate enables
// - Receive only after four idle half-bits
// - Forward frame end sets done, receive state
// - Backward frame end sets done, transmit state
// - Acknowledge with transmit state starts backward frame
// - Acknowledge after transmit re-arms forward reception
// - Deferred reply: force-transmit later sends backward byte
// - Force-transmit pulse of one cycle suffices
// - Divider low byte at 0x00, resets zero
// - Divider bits 9:8 at 0x01, rest reserved
// - Message byte 0 readable at 0x02
// - Message byte 1 readable at 0x03
// - Acknowledge bit clears itself after write
// - Length codes select 16, 17, 18, 24 bits
// - Force-transmit sends once any frame in progress ends, ignoring transmit-state bit
// - Done flag set at frame end, cleared by acknowledge
package lbfh_pkg;

  localparam int ADDR_W = 4;
  localparam int BYTE_W = 8;
  localparam int DIV_W = 10;

  localparam logic [3:0] OFS_DIV_LO = 4'h0;
  localparam logic [3:0] OFS_DIV_HI = 4'h1;
  localparam logic [3:0] OFS_FB0 = 4'h2;
  localparam logic [3:0] OFS_FB1 = 4'h3;
  localparam logic [3:0] OFS_FB2 = 4'h4;
  localparam logic [3:0] OFS_BD = 4'h5;
  localparam logic [3:0] OFS_CTRL = 4'h6;
  localparam logic [3:0] OFS_CSR = 4'h7;
  localparam logic [3:0] OFS_CSR1 = 4'h8;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  localparam int CR_FTS = 0;
  localparam int CR_RTS = 1;
  localparam int CR_RTA = 2;
  localparam int CR_COMM_ENABLE_BIT = 3;
  localparam int CR_MLN_LO = 4;
  localparam int CR_MLN_HI = 5;
  localparam int CR_SMK = 6;
  localparam int CR_WDG_EN = 7;

  localparam int CSR_LINE_WATCHDOG_FLAG = 2;
  localparam int CSR_LINE_WATCHDOG_IRQ_ENABLE = 3;
  localparam int CSR_RTF = 4;
  localparam int CSR_EF = 5;
  localparam int CSR_ITF = 6;
  localparam int CSR_IEN = 7;
  localparam int CSR1_RDY = 3;

  localparam logic [1:0] MLN_16 = 2'h0;
  localparam logic [1:0] MLN_17 = 2'h1;
  localparam logic [1:0] MLN_18 = 2'h2;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_17 = 5'h11;
  localparam logic [4:0] LEN_18 = 5'h12;
  localparam logic [4:0] LEN_24 = 5'h18;
  localparam int MSG_W = 24;

  localparam int TICKS_PER_HALF = 16;
  localparam logic [3:0] SAMPLE_TICK = 4'h8;
  localparam logic [3:0] LAST_TICK = 4'(TICKS_PER_HALF - 1);
  localparam int IDLE_HALVES = 4;
  localparam logic [6:0] IDLE_LAST = 7'(IDLE_HALVES * TICKS_PER_HALF - 1);

  localparam int TX_BITS = 9;
  localparam int TX_STOP_HALVES = 4;
  localparam logic [4:0] TX_DATA_HALVES = 5'(2 * TX_BITS);
  localparam logic [4:0] TX_LAST_HALF = 5'(2 * TX_BITS + TX_STOP_HALVES - 1);

  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_FREQ_KHZ = 1000000 / CLK_PERIOD_NS;
  localparam int WDG_TIME_MS = 500;
  localparam int WDG_CYCLES_DEF = WDG_TIME_MS * CLK_FREQ_KHZ;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_IDLE_WAIT,
    ST_READY,
    ST_RX,
    ST_ACK_WAIT,
    ST_TX
  } lbfh_state_t;

endpackage

// *** logic/lbfh_prescaler.sv ***
`timescale 1ns/100ps
module lbfh_prescaler
  import lbfh_pkg::*;
#(
  parameter int DIV_WIDTH = DIV_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic enable,
  input wire logic [DIV_WIDTH-1:0] divisor,
  output logic tick
);

  logic [DIV_WIDTH-1:0] cnt_q;

  generate
    if (DIV_WIDTH < 1 || DIV_WIDTH > 16) begin : g_bad_width
      $error("Divider width out of range");
    end
  endgenerate

  // Compare with >= so a divisor lowered mid-count cannot run away
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (run) begin
      if (!enable) begin
        cnt_q <= '0;
        tick <= 1'b0;
      end else if (cnt_q >= divisor) begin
        cnt_q <= '0;
        tick <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
        tick <= 1'b0;
      end
    end
  end

endmodule

// *** logic/lbfh_top.sv ***
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module lbfh_top
  import lbfh_pkg::*;
#(
  parameter int WDG_CYCLES = WDG_CYCLES_DEF
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [BYTE_W-1:0] WDATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [BYTE_W-1:0] RDATA,
  input wire logic HALT_MODE,
  input wire logic RX_LINE,
  output logic TX_LINE,
  output logic IRQ
);

  localparam int WDG_W = $clog2(WDG_CYCLES + 1);

  generate
    if (WDG_CYCLES < 2) begin : g_bad_wdg
      $error("Watchdog count too small");
    end
  endgenerate

  lbfh_state_t state_q, state_d;
  logic run;
  logic tick, tick_act;
  logic [DIV_W-1:0] div_q;
  logic [BYTE_W-1:0] bd_q;
  logic [1:0] mln_q;
  logic smk_q, comm_enable_bit_q, rts_q, fts_q, ack_q, wdg_en_q;
  logic ien_q, line_watchdog_irq_enable_q, itf_q, rtf_q, ef_q, line_watchdog_flag_q;
  logic fts_prev_q, fts_req_q, comm_enable_bit_set;
  logic [MSG_W-1:0] fb_q, shift_q;
  logic [3:0] t_cnt_q;
  logic [4:0] half_q, bit_cnt_q, msg_len, stop_idx;
  logic [6:0] idle_cnt_q;
  logic [WDG_W-1:0] wdg_cnt_q;
  logic h0_q, rx_last_q, rx_edge, samp, stop_phase, pair_ok;
  logic rx_done, tx_done, rx_err, enter_tx;
  logic [3:0] tx_idx;
  logic [TX_BITS-1:0] tx_frame;
  logic [BYTE_W-1:0] rd_d;

  // Halt freezes every register except RDATA and gap_ok_q; wait mode needs no input at all
  assign run = !HALT_MODE;
  assign tick_act = tick && run;
  // Only a fresh enable restarts the machine; rewriting the bit during a handshake must not
  assign comm_enable_bit_set = WR_EN && ADDR == OFS_CTRL && WDATA[CR_COMM_ENABLE_BIT] && !comm_enable_bit_q;

  lbfh_prescaler #(
    .DIV_WIDTH(DIV_W)
  ) lbfh_prescaler_i (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .run(run),
    .enable(comm_enable_bit_q),
    .divisor(div_q),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_q <= '0;
      bd_q <= RESET_BYTE;
      {wdg_en_q, smk_q, mln_q, comm_enable_bit_q, ack_q, rts_q, fts_q} <= RESET_BYTE;
      ien_q <= 1'b0;
      line_watchdog_irq_enable_q <= 1'b0;
    end else if (run) begin
      ack_q <= 1'b0;
      if (WR_EN) begin
        if (ADDR == OFS_DIV_LO) begin
          div_q[BYTE_W-1:0] <= WDATA;
        end else if (ADDR == OFS_DIV_HI) begin
          div_q[DIV_W-1:BYTE_W] <= WDATA[DIV_W-BYTE_W-1:0];
        end else if (ADDR == OFS_BD) begin
          bd_q <= WDATA;
        end else if (ADDR == OFS_CTRL) begin
          wdg_en_q <= WDATA[CR_WDG_EN];
          smk_q <= WDATA[CR_SMK];
          mln_q <= WDATA[CR_MLN_HI:CR_MLN_LO];
          comm_enable_bit_q <= WDATA[CR_COMM_ENABLE_BIT];
          ack_q <= WDATA[CR_RTA];
          rts_q <= WDATA[CR_RTS];
          fts_q <= WDATA[CR_FTS];
        end else if (ADDR == OFS_CSR) begin
          ien_q <= WDATA[CSR_IEN];
          line_watchdog_irq_enable_q <= WDATA[CSR_LINE_WATCHDOG_IRQ_ENABLE];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame state machine

  always_comb begin
    case (mln_q)
      MLN_16: msg_len = LEN_16;
      MLN_17: msg_len = LEN_17;
      MLN_18: msg_len = LEN_18;
      default: msg_len = LEN_24;
    endcase
  end

  assign stop_idx = 5'(msg_len + 5'h01);
  assign rx_edge = RX_LINE != rx_last_q;
  assign samp = tick_act && !rx_edge && t_cnt_q == SAMPLE_TICK;
  assign stop_phase = bit_cnt_q == stop_idx;
  // Start bit is low then high; every bit must change mid-way
  assign pair_ok = (h0_q != RX_LINE) && (bit_cnt_q != 5'h00 || RX_LINE);
  assign enter_tx = state_q != ST_TX && state_d == ST_TX;

  always_comb begin
    state_d = state_q;
    rx_done = 1'b0;
    tx_done = 1'b0;
    rx_err = 1'b0;
    if (!comm_enable_bit_q) begin
      state_d = ST_OFF;
    end else if (comm_enable_bit_set) begin
      state_d = ST_IDLE_WAIT;
    end else begin
      case (state_q)
        ST_OFF: begin
          state_d = ST_IDLE_WAIT;
        end
        ST_IDLE_WAIT: begin
          if (fts_req_q) begin
            state_d = ST_TX;
          end else if (tick_act && RX_LINE && idle_cnt_q == IDLE_LAST) begin
            state_d = ST_READY;
          end
        end
        ST_READY: begin
          if (fts_req_q) begin
            state_d = ST_TX;
          end else if (tick_act && !RX_LINE) begin
            state_d = ST_RX;
          end
        end
        ST_RX: begin
          if (samp && stop_phase) begin
            rx_done = RX_LINE;
            rx_err = !RX_LINE;
            state_d = RX_LINE ? ST_ACK_WAIT : ST_IDLE_WAIT;
          end else if (samp && half_q[0] && !pair_ok) begin
            rx_err = 1'b1;
            state_d = ST_IDLE_WAIT;
          end
        end
        ST_ACK_WAIT: begin
          if (fts_req_q) begin
            state_d = ST_TX;
          end else if (ack_q) begin
            state_d = (rtf_q && rts_q) ? ST_TX : ST_IDLE_WAIT;
          end
        end
        ST_TX: begin
          if (tick_act && t_cnt_q == LAST_TICK && half_q == TX_LAST_HALF) begin
            tx_done = 1'b1;
            state_d = ST_ACK_WAIT;
          end
        end
        default: begin
          state_d = ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= ST_OFF;
    end else if (run) begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase counters and receive shifter

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      t_cnt_q <= 4'h0;
      half_q <= 5'h00;
      bit_cnt_q <= 5'h00;
      h0_q <= 1'b0;
      shift_q <= '0;
      rx_last_q <= 1'b1;
    end else if (run) begin
      if (tick) begin
        rx_last_q <= RX_LINE;
      end
      if (state_q != state_d) begin
        t_cnt_q <= 4'h0;
        half_q <= 5'h00;
        bit_cnt_q <= 5'h00;
        if (state_d == ST_RX) begin
          shift_q <= '0;
        end
      end else if (tick) begin
        // Every line edge re-centres the sample point
        if (state_q == ST_RX && rx_edge) begin
          t_cnt_q <= 4'h0;
        end else begin
          t_cnt_q <= t_cnt_q + 4'h1;
        end
        if (state_q == ST_TX && t_cnt_q == LAST_TICK) begin
          half_q <= half_q + 5'h01;
        end else if (state_q == ST_RX && samp) begin
          half_q <= half_q + 5'h01;
          if (!half_q[0]) begin
            h0_q <= RX_LINE;
          end else begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q != 5'h00) begin
              shift_q <= {shift_q[MSG_W-2:0], RX_LINE};
            end
          end
        end
      end
    end
  end

  // Idle time counts only while the line stays high
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      idle_cnt_q <= 7'h00;
    end else if (run) begin
      if (state_q != ST_IDLE_WAIT || !RX_LINE) begin
        idle_cnt_q <= 7'h00;
      end else if (tick && idle_cnt_q != IDLE_LAST) begin
        idle_cnt_q <= idle_cnt_q + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Force-transmit catch and status flags

  // A one-cycle pulse on the bit is latched so it cannot be missed
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fts_prev_q <= 1'b0;
      fts_req_q <= 1'b0;
    end else if (run) begin
      fts_prev_q <= fts_q;
      fts_req_q <= (fts_q && !fts_prev_q) || (fts_req_q && !enter_tx);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      itf_q <= 1'b0;
      rtf_q <= 1'b0;
      ef_q <= 1'b0;
      fb_q <= '0;
    end else if (run) begin
      itf_q <= rx_done || tx_done || (itf_q && !ack_q);
      if (rx_done) begin
        rtf_q <= 1'b1;
        fb_q <= shift_q;
      end else if (tx_done) begin
        rtf_q <= 1'b0;
      end
      ef_q <= rx_err || (ef_q && !(WR_EN && ADDR == OFS_CSR && WDATA[CSR_EF]));
    end
  end

  // Line held low too long; flag drops only with the monitor enable
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wdg_cnt_q <= '0;
      line_watchdog_flag_q <= 1'b0;
    end else if (run) begin
      if (!wdg_en_q || RX_LINE) begin
        wdg_cnt_q <= '0;
      end else if (wdg_cnt_q != WDG_W'(WDG_CYCLES - 1)) begin
        wdg_cnt_q <= wdg_cnt_q + 1'b1;
      end
      if (wdg_en_q && !RX_LINE && wdg_cnt_q == WDG_W'(WDG_CYCLES - 1)) begin
        line_watchdog_flag_q <= 1'b1;
      end else if (!wdg_en_q) begin
        line_watchdog_flag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port and pins

  always_comb begin
    if (ADDR == OFS_DIV_LO) begin
      rd_d = div_q[BYTE_W-1:0];
    end else if (ADDR == OFS_DIV_HI) begin
      rd_d = BYTE_W'(div_q[DIV_W-1:BYTE_W]);
    end else if (ADDR == OFS_FB0) begin
      rd_d = fb_q[7:0];
    end else if (ADDR == OFS_FB1) begin
      rd_d = fb_q[15:8];
    end else if (ADDR == OFS_FB2) begin
      rd_d = fb_q[23:16];
    end else if (ADDR == OFS_BD) begin
      rd_d = bd_q;
    end else if (ADDR == OFS_CTRL) begin
      rd_d = {wdg_en_q, smk_q, mln_q, comm_enable_bit_q, ack_q, rts_q, fts_q};
    end else if (ADDR == OFS_CSR) begin
      rd_d = {ien_q, itf_q, ef_q, rtf_q, line_watchdog_irq_enable_q, line_watchdog_flag_q, 2'h0};
    end else if (ADDR == OFS_CSR1) begin
      rd_d = BYTE_W'({state_q == ST_READY, 3'h0});
    end else begin
      rd_d = RESET_BYTE;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= RESET_BYTE;
    end else if (RD_EN) begin
      RDATA <= rd_d;
    end else begin
      RDATA <= RESET_BYTE;
    end
  end

  assign tx_frame = {1'b1, bd_q};
  assign tx_idx = 4'(TX_BITS - 1) - 4'(half_q[4:1]);

  // Bit value sits in the second half, its inverse in the first
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TX_LINE <= 1'b1;
      IRQ <= 1'b0;
    end else if (run) begin
      if (state_q == ST_TX && half_q < TX_DATA_HALVES) begin
        TX_LINE <= half_q[0] ? tx_frame[tx_idx] : !tx_frame[tx_idx];
      end else begin
        TX_LINE <= 1'b1;
      end
      IRQ <= (itf_q && ien_q) || (line_watchdog_flag_q && line_watchdog_irq_enable_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [DIV_W-1:0] gap_q;
  logic gap_ok_q;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      gap_q <= '0;
      gap_ok_q <= 1'b0;
    end else if (!comm_enable_bit_q || (WR_EN && (ADDR == OFS_DIV_LO || ADDR == OFS_DIV_HI))) begin
      gap_ok_q <= 1'b0;
    end else if (run) begin
      gap_q <= tick ? '0 : gap_q + 1'b1;
      gap_ok_q <= gap_ok_q || tick;
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_fb0_read;
    RD_EN && ADDR == OFS_FB0;
  endsequence

  sequence s_fb1_read;
    RD_EN && ADDR == OFS_FB1;
  endsequence

  sequence s_idle_to_ready;
    state_q == ST_IDLE_WAIT ##1 state_q == ST_READY;
  endsequence

  sequence s_tx_ack;
    run && comm_enable_bit_q && !comm_enable_bit_set && state_q == ST_ACK_WAIT && ack_q && rtf_q && rts_q;
  endsequence

  a_tick_period: assert property (tick_act && gap_ok_q |-> gap_q == div_q)
    else $error("Sample tick spacing differs from divider");
  a_halt_frozen: assert property (HALT_MODE |=> $stable(state_q) && $stable(fb_q))
    else $error("State moved during halt");
  a_ack_selfclr: assert property (ack_q && run |=> !ack_q)
    else $error("Acknowledge bit did not self clear");
  a_rx_end_flags: assert property (rx_done |=> itf_q && rtf_q && fb_q == $past(shift_q))
    else $error("Forward frame end flags wrong");
  a_tx_end_flags: assert property (tx_done |=> itf_q && !rtf_q ##0 state_q == ST_ACK_WAIT)
    else $error("Backward frame end flags wrong");
  a_ack_clears: assert property (ack_q && run && !rx_done && !tx_done |=> !itf_q)
    else $error("Acknowledge did not clear done flag");
  a_ack_starts_tx: assert property (s_tx_ack |=> state_q == ST_TX ##1 !TX_LINE)
    else $error("Backward frame did not start on acknowledge");
  a_ack_rearms_rx: assert property (run && comm_enable_bit_q && !comm_enable_bit_set && state_q == ST_ACK_WAIT
      && ack_q && !rtf_q && !fts_req_q |=> state_q == ST_IDLE_WAIT)
    else $error("Reception not re-armed");
  a_fts_catch: assert property (run && fts_q && !fts_prev_q |=> fts_req_q || state_q == ST_TX)
    else $error("Force-transmit pulse lost");
  a_fts_starts_tx: assert property (run && comm_enable_bit_q && !comm_enable_bit_set && fts_req_q
      && state_q inside {ST_IDLE_WAIT, ST_READY, ST_ACK_WAIT} |=> state_q == ST_TX)
    else $error("Force-transmit did not start transmission");
  a_idle_time: assert property (s_idle_to_ready |-> $past(idle_cnt_q) == IDLE_LAST)
    else $error("Receiver armed before idle time");
  a_msg_length: assert property (rx_done |-> bit_cnt_q == 5'(msg_len + 5'h01))
    else $error("Frame length not as selected");
  a_fb_hold: assert property (!rx_done |=> $stable(fb_q))
    else $error("Message registers changed outside frame end");
  a_fb0_read: assert property (s_fb0_read |=> RDATA == $past(fb_q[7:0]))
    else $error("Message byte 0 read wrong");
  a_fb1_read: assert property (s_fb1_read |=> RDATA == $past(fb_q[15:8]))
    else $error("Message byte 1 read wrong");
  a_div_hi_write: assert property (run && WR_EN && ADDR == OFS_DIV_HI
      |=> div_q[DIV_W-1:BYTE_W] == $past(WDATA[1:0]))
    else $error("Divider high bits not stored");
  a_irq_quiet: assert property (run && !(itf_q && ien_q) && !(line_watchdog_flag_q && line_watchdog_irq_enable_q) |=> !IRQ)
    else $error("Interrupt without enabled source");

endmodule

// *** verification/lbfh_bus_master_model.sv ***
`timescale 1ns/100ps
module lbfh_bus_master_model (
  input wire logic clk,
  output logic rx_line,
  input wire logic tx_line
);
  int half = 32;

  initial rx_line = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic hold(input logic lvl, input int n);
    rx_line <= lvl;
    repeat (n) @(posedge clk);
  endtask

  // Start bit, then bits MSB first; a bad frame gives the first bit equal halves
  task automatic send(input logic [23:0] d, input int nb, input bit bad);
    hold(1'h1, 5 * half);
    hold(1'h0, half);
    hold(1'h1, half);
    if (bad) begin
      hold(1'h0, 2 * half);
      hold(1'h1, 2 * half);
      return;
    end
    for (int i = nb - 1; i >= 0; i--) begin
      hold(~d[i], half);
      hold(d[i], half);
    end
    hold(1'h1, 2 * half);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Samples mid-half; first half must be the inverse of the second
  task automatic recv(output logic [7:0] b, output int low_len, output bit ok);
    int t;
    logic f;
    ok = 0;
    for (t = 0; t < 40 * half && tx_line !== 1'h0; t++) @(posedge clk);
    if (tx_line !== 1'h0) return;
    for (low_len = 0; tx_line === 1'h0 && low_len < 4 * half; low_len++) @(posedge clk);
    repeat (half / 2) @(posedge clk);
    ok = 1;
    for (int i = 7; i >= 0; i--) begin
      repeat (half) @(posedge clk);
      f = tx_line;
      repeat (half) @(posedge clk);
      b[i] = tx_line;
      ok = ok && (f === ~tx_line);
    end
    repeat (half) @(posedge clk);
    ok = ok && (tx_line === 1'h1);
  endtask
endmodule

// *** verification/tb_lighting_bus_frame_handler.sv ***
`timescale 1ns/100ps
module tb_lighting_bus_frame_handler;
  import lbfh_pkg::*;
  // Divider N=1: a tick every two clocks, sixteen ticks a half-bit
  localparam int HALF = 32;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'h0;
  logic rd_en = 1'h0;
  logic halt_mode = 1'h0;
  logic [7:0] rdata;
  logic rx_line;
  logic tx_line;
  logic irq;
  int bad_count = 0;
  int checks_done = 0;
  int nbits[4] = '{16, 17, 18, 24};

  always #2 clk = ~clk;

  lbfh_top #(.WDG_CYCLES(50)) lbfh_top_i (.CORE_CLK(clk), .RESET_N(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en), .RDATA(rdata), .HALT_MODE(halt_mode),
    .RX_LINE(rx_line), .TX_LINE(tx_line), .IRQ(irq));
  lbfh_bus_master_model lbfh_bus_master_model_i (.clk(clk), .rx_line(rx_line),
    .tx_line(tx_line));

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask

  // Strobes drop for one cycle between calls so no signal is set twice per step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rdc(input string w, input logic [3:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1;
    chk(w, e, rdata & m);
    @(posedge clk);
  endtask

  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clk);
    chk("irq", {7'h00, e}, {7'h00, irq});
  endtask

  task automatic wait_irq(input int lim);
    for (int n = 0; n < lim && irq !== 1'h1; n++) @(posedge clk);
    if (irq !== 1'h1) begin
      chk("irq wait", 8'h01, {7'h00, irq});
      conclude();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    chk("run time limit", 8'h00, 8'h01);
    conclude();
  end

  initial begin
    logic [7:0] b;
    logic [23:0] d;
    logic [23:0] m;
    int low_len;
    bit ok;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    for (int a = 0; a < 9; a++) rdc("reset value", 4'(a), 8'hFF, 8'h00);
    rdc("unmapped", 4'hF, 8'hFF, 8'h00);
    wr(4'h0, 8'hA5);
    rdc("divider low", 4'h0, 8'hFF, 8'hA5);
    wr(4'h1, 8'hFF);
    rdc("divider high", 4'h1, 8'hFF, 8'h03);
    wr(4'h3, 8'h55);
    rdc("message ro", 4'h3, 8'hFF, 8'h00);
    halt_mode <= 1'h1;
    wr(4'h0, 8'h77);
    rdc("halted write", 4'h0, 8'hFF, 8'hA5);
    halt_mode <= 1'h0;
    // Reserved high bits written as zero, enable set last
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h01);
    wr(4'h7, 8'h80);
    wr(4'h6, 8'h08);
    lbfh_bus_master_model_i.send(24'h00A53C, 16, 0);
    wait_irq(300);
    rdc("status rx", 4'h7, 8'hFF, 8'hD0);
    rdc("msg byte0", 4'h2, 8'hFF, 8'h3C);
    rdc("msg byte1", 4'h3, 8'hFF, 8'hA5);
    wr(4'h7, 8'h00);
    irq_chk(1'h0);
    wr(4'h7, 8'h80);
    irq_chk(1'h1);
    ////////////////////////////////////////////////////////////////////////
    wr(4'h5, 8'h5A);
    wr(4'h6, 8'h0A);
    wr(4'h6, 8'h0E);
    lbfh_bus_master_model_i.recv(b, low_len, ok);
    chk("backward byte", 8'h5A, b);
    chk("backward coding", 8'h01, {7'h00, ok});
    chk("start low clocks", 8'(HALF), 8'(low_len));
    rdc("ack self clear", 4'h6, 8'hFF, 8'h0A);
    rdc("done cleared", 4'h7, 8'h40, 8'h00);
    wait_irq(300);
    rdc("status tx", 4'h7, 8'h50, 8'h40);
    d = 24'hC396E1;
    for (int k = 0; k < 4; k++) begin
      wr(4'h6, {2'h0, 2'(k), 4'hC});
      irq_chk(1'h0);
      lbfh_bus_master_model_i.send(d, nbits[k], 0);
      wait_irq(300);
      m = (24'h000001 << nbits[k]) - 24'h000001;
      rdc("len byte0", 4'h2, 8'hFF, d[7:0] & m[7:0]);
      rdc("len byte1", 4'h3, 8'hFF, d[15:8] & m[15:8]);
      rdc("len byte2", 4'h4, 8'hFF, d[23:16] & m[23:16]);
    end
    ////////////////////////////////////////////////////////////////////////
    wr(4'h6, 8'h3C);
    lbfh_bus_master_model_i.send(24'h0F0F0F, 24, 1);
    rdc("error no done", 4'h7, 8'h60, 8'h20);
    rdc("msg kept", 4'h2, 8'hFF, d[7:0]);
    wr(4'h5, 8'h81);
    wr(4'h6, 8'h39);
    wr(4'h6, 8'h38);
    lbfh_bus_master_model_i.recv(b, low_len, ok);
    chk("forced byte", 8'h81, b);
    chk("forced coding", 8'h01, {7'h00, ok});
    wait_irq(300);
    rdc("forced done", 4'h7, 8'h50, 8'h40);
    wr(4'h6, 8'h0C);
    wr(4'h7, 8'h08);
    wr(4'h6, 8'h88);
    lbfh_bus_master_model_i.hold(1'h0, 100);
    rdc("watchdog flag", 4'h7, 8'h04, 8'h04);
    irq_chk(1'h1);
    wr(4'h6, 8'h08);
    irq_chk(1'h0);
    lbfh_bus_master_model_i.hold(1'h1, 4);
    conclude();
  end
endmodule
